/* logic/clock_gear_map.vh */
`ifndef CLOCK_GEAR_MAP_VH
`define CLOCK_GEAR_MAP_VH
// Register indices; byte address is four times the index
`define IDX_SYSCTL_A     10'h0E0
`define IDX_SYSCTL_B     10'h0E1
`define IDX_SYSCTL_C     10'h0E2
`define IDX_NOISE_A      10'h0E3
`define IDX_NOISE_B      10'h0E4
`define IDX_IDLE_RUN     10'h0E5
// Field positions
`define A_WARM_BIT       2
`define C_WARM_HI        5
`define C_WARM_LO        4
`define C_HALT_HI        3
`define C_HALT_LO        2
`define C_DRIVE_BIT      0
`define NA_PROT_BIT      7
`define NA_EXT_BIT       2
// Reset values, fixed read values and unprotect key
`define RST_PRESC        2'h0
`define RST_GEAR         3'h4
`define RST_WARM         2'h2
`define RST_HALT         2'h3
`define RST_IDLE_RUN     5'h00
`define FIX_SYSCTL_A     8'hA0
`define FIX_NOISE_A      8'h23
`define UNPROTECT_KEY    8'h1F
// Halt kinds
`define HALT_STOP        2'h1
`define HALT_OSC_IDLE    2'h2
`define HALT_PERIPH_IDLE 2'h3
// Prescaler source
`define PRESC_FIXED      2'h2
// Timing counts in input clock cycles and gear ticks
`define WARM_SHORT       17'd256
`define WARM_MID         16384
`define WARM_LONG        65536
`define ENTER_TICKS      3'd5
`endif

/* logic/clock_gear_standby_controller.v */
// Notes on behaviour
// R1: Gear clock is input clock divided by 1, 2, 4, 8 or 16 per divide select.
// R2: Reset gear select is 100, giving system clock of input clock over 32.
// R3: Gear 000 gives system clock input/2; gear 001 gives input/4.
// R4: A new gear ratio takes effect only after the warm-up time elapses.
// R5: Software issues a dummy write after changing the gear select.
// R6: Prescaler base A is gear clock/2 or input/16/2 per source select.
// R7: Prescaler base B is gear clock/4 or input/16/4, same source select.
// R8: Source 00 picks gear path, 10 the fixed path; 01 and 11 reserved.
// R9: External clock single-drive bit resets to 0, resonator drive.
// R10: Software never sets single-drive while a resonator is fitted.
// R11: While protection is on, writes to protected registers are blocked.
// R12: Read-only protect flag shows 0 when off and 1 when on.
// R13: Halt request enters mode by halt kind: 10 oscillator idle, 01 stop.
// R14: Peripheral idle halts CPU; each peripheral runs if its enable is set.
// R15: In both idle modes pins hold state and interrupt logic stays active.
// R16: Oscillator idle stops system clock; oscillator and RTC keep running.
// R17: Stop halts everything incl. oscillator; pin drive follows drive bit.
// R18: Leaving stop, system clock restarts after selected warm-up count.
// R19: Warm-up is a counter on the input clock of selected length.
// R20: Interrupt at or above mask, or non-maskable, wakes and is serviced.
// R21: Below mask no wake, except external wake inputs: wake, no service.
// R22: Oscillator idle and stop wake only on non-maskable or external inputs.
// R23: Stop ended by interrupt releases halt only after warm-up time.
// R24: Wake during 5-tick entry is held; a later interrupt wakes, both served.
// R25: Wake inputs sampled asynchronously; restart synchronous to clock.
// R26: Reset ends any halt and restores all settings; wake keeps them.
// R27: Reset ending stop must allow 3 ms for the oscillator to settle.
// R28: A level-mode external wake must hold until servicing begins.
`timescale 1ns/1ps
`include "clock_gear_map.vh"

module clock_gear_standby_controller #(
   parameter WARM_MID_CYC  = `WARM_MID,
   parameter WARM_LONG_CYC = `WARM_LONG
) (
   // Clock and reset
   input  wire        pclk,
   input  wire        presetn,
   // APB slave
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [11:0] paddr,
   input  wire [31:0] pwdata,
   output wire        pready,
   output wire [31:0] prdata,
   output wire        pslverr,
   // CPU side
   input  wire        halt_req,
   input  wire [2:0]  interrupt_mask_level,
   input  wire        periph_irq,
   input  wire [2:0]  periph_irq_level,
   input  wire [2:0]  ext_irq_level,
   output reg         wake_service,
   output reg         wake_resume,
   output reg         cpu_halted,
   // Wake pins
   input  wire        nmi_pin,
   input  wire [4:0]  external_wake_interrupts,
   // Clock enables
   output reg         gear_clock,
   output reg         sys_clk_en,
   output reg         prescaler_base_a,
   output reg         prescaler_base_b,
   // Oscillator and pins
   output reg         osc_run,
   output reg         external_clock_single_drive,
   output reg         pin_hold,
   output reg         stop_pin_drive_enable,
   // Peripheral run enables
   output reg         timer_pair0_run,
   output reg         timer16_run,
   output reg         serial_run,
   output reg         converter_run,
   output reg         watchdog_run
);

   localparam ST_RUN   = 2'd0;
   localparam ST_ENTER = 2'd1;
   localparam ST_HALT  = 2'd2;
   localparam ST_WARM  = 2'd3;

   reg  [1:0]  prescaler_source_select_r;
   reg  [2:0]  clock_divide_select_r;
   reg  [2:0]  gear_pend_r;
   reg         gear_pend_v_r;
   reg  [1:0]  warmup_length_select_r;
   reg  [1:0]  halt_kind_select_r;
   reg         protect_r;
   reg  [4:0]  idle_run_r;
   reg  [16:0] wu_cnt_r;
   reg         wu_busy_r;
   reg  [4:0]  div_r;
   reg  [1:0]  gph_r;
   reg  [1:0]  fph_r;
   reg         sph_r;
   reg  [1:0]  st_r;
   reg  [1:0]  mode_r;
   reg  [2:0]  ent_cnt_r;
   reg         hold_r;
   reg         svc_r;
   reg  [5:0]  sync1_r;
   reg  [5:0]  sync2_r;
   reg  [7:0]  rdata_r;

   wire [9:0]  idx;
   wire        wr;
   wire        mapped;
   wire        wr_ok;
   wire        gear_tick;
   wire        fix_tick;
   wire        run_clk;
   wire        nmi_s;
   wire        ext_s;
   wire        per_ok;
   wire        ext_svc;
   wire        wake;
   wire        svc;
   wire        wu_start_sw;
   wire        wu_done;

   function [4:0] gear_mask;
      input [2:0] sel;
      begin
         case (sel)
            3'h0:    gear_mask = 5'h00;
            3'h1:    gear_mask = 5'h01;
            3'h2:    gear_mask = 5'h03;
            3'h3:    gear_mask = 5'h07;
            default: gear_mask = 5'h0F;
         endcase
      end
   endfunction

   function [16:0] warm_len;
      input [1:0] sel;
      begin
         case (sel)
            2'h2:    warm_len = WARM_MID_CYC[16:0];
            2'h3:    warm_len = WARM_LONG_CYC[16:0];
            default: warm_len = `WARM_SHORT;
         endcase
      end
   endfunction

   assign idx     = paddr[11:2];
   assign wr      = psel & penable & pwrite;
   assign mapped  = (idx >= `IDX_SYSCTL_A) && (idx <= `IDX_IDLE_RUN);
   assign wr_ok   = wr & (~protect_r | (idx == `IDX_NOISE_B)); // R11
   assign pready  = 1'b1;
   assign pslverr = psel & penable & ~mapped;
   assign prdata  = {24'h000000, rdata_r};

   // Gear path only ticks while the oscillator and gear run
   assign run_clk   = osc_run & ~(st_r == ST_WARM);
   assign gear_tick = run_clk & ((div_r & gear_mask(clock_divide_select_r))
                      == gear_mask(clock_divide_select_r)); // R1
   assign fix_tick  = run_clk & (div_r[3:0] == 4'hF);

   assign nmi_s   = sync2_r[5];
   assign ext_s   = |sync2_r[4:0];
   assign per_ok  = periph_irq & (periph_irq_level >= interrupt_mask_level);
   assign ext_svc = ext_s & (ext_irq_level >= interrupt_mask_level);
   // Only pins wake the deeper modes; held events alone do not
   assign wake = nmi_s | ext_s | ((mode_r == `HALT_PERIPH_IDLE) & per_ok); // R20 R21 R22 R24
   assign svc  = nmi_s | ext_svc | hold_r
                 | ((mode_r == `HALT_PERIPH_IDLE) & per_ok); // R20 R21
   assign wu_start_sw = wr_ok & (idx == `IDX_SYSCTL_A) & pwdata[`A_WARM_BIT];
   assign wu_done = wu_busy_r & (wu_cnt_r == 17'd1);

   // Pin synchroniser
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync1_r <= 6'h00;
         sync2_r <= 6'h00;
      end else begin
         sync1_r <= {nmi_pin, external_wake_interrupts}; // R25
         sync2_r <= sync1_r;
      end
   end

   // Register file
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prescaler_source_select_r   <= `RST_PRESC;
         clock_divide_select_r       <= `RST_GEAR; // R2 R26
         gear_pend_r                 <= `RST_GEAR;
         gear_pend_v_r               <= 1'b0;
         warmup_length_select_r      <= `RST_WARM;
         halt_kind_select_r          <= `RST_HALT;
         stop_pin_drive_enable       <= 1'b0;
         external_clock_single_drive <= 1'b0; // R9
         protect_r                   <= 1'b0;
         idle_run_r                  <= `RST_IDLE_RUN;
      end else begin
         if (gear_pend_v_r && wu_done) begin
            clock_divide_select_r <= gear_pend_r; // R3 R4
            gear_pend_v_r         <= 1'b0;
         end
         if (wr_ok) begin
            case (idx)
               `IDX_SYSCTL_A: prescaler_source_select_r <= pwdata[1:0];
               `IDX_SYSCTL_B: begin
                  gear_pend_r   <= pwdata[2:0];
                  gear_pend_v_r <= 1'b1;
               end
               `IDX_SYSCTL_C: begin
                  warmup_length_select_r <= pwdata[`C_WARM_HI:`C_WARM_LO];
                  halt_kind_select_r     <= pwdata[`C_HALT_HI:`C_HALT_LO];
                  stop_pin_drive_enable  <= pwdata[`C_DRIVE_BIT];
               end
               `IDX_NOISE_A: external_clock_single_drive <= pwdata[`NA_EXT_BIT];
               `IDX_NOISE_B: protect_r <= (pwdata[7:0] != `UNPROTECT_KEY);
               `IDX_IDLE_RUN: idle_run_r <= pwdata[4:0];
               default: ;
            endcase
         end
      end
   end

   // Read mux
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rdata_r <= 8'h00;
      end else if (psel && !penable && !pwrite) begin
         case (idx)
            `IDX_SYSCTL_A: rdata_r <= `FIX_SYSCTL_A | {5'h00, wu_busy_r, prescaler_source_select_r};
            `IDX_SYSCTL_B: rdata_r <= {5'h00, clock_divide_select_r};
            `IDX_SYSCTL_C: rdata_r <= {2'h0, warmup_length_select_r, halt_kind_select_r,
                                       1'b0, stop_pin_drive_enable};
            `IDX_NOISE_A:  rdata_r <= `FIX_NOISE_A | {protect_r, 4'h0, external_clock_single_drive, 2'h0}; // R12
            `IDX_IDLE_RUN: rdata_r <= {3'h0, idle_run_r};
            default:       rdata_r <= 8'h00;
         endcase
      end
   end

   // Warm-up counter on the input clock
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wu_cnt_r  <= 17'd0;
         wu_busy_r <= 1'b0;
      end else if ((st_r == ST_HALT && wake && mode_r == `HALT_STOP) || wu_start_sw
                   || (wr_ok && idx == `IDX_SYSCTL_B)) begin
         wu_cnt_r  <= warm_len(warmup_length_select_r); // R19
         wu_busy_r <= 1'b1;
      end else if (wu_busy_r) begin
         wu_cnt_r  <= wu_cnt_r - 17'd1;
         wu_busy_r <= ~wu_done;
      end
   end

   // Dividers
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div_r <= 5'h00;
         gph_r <= 2'h0;
         fph_r <= 2'h0;
         sph_r <= 1'b0;
      end else begin
         if (run_clk)
            div_r <= div_r + 5'h01;
         if (gear_tick)
            gph_r <= gph_r + 2'h1;
         if (fix_tick)
            fph_r <= fph_r + 2'h1;
         if (gear_tick)
            sph_r <= ~sph_r;
      end
   end

   // Clock enable outputs
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         gear_clock       <= 1'b0;
         sys_clk_en       <= 1'b0;
         prescaler_base_a <= 1'b0;
         prescaler_base_b <= 1'b0;
      end else begin
         gear_clock <= gear_tick;
         // System clock is half the gear clock; stopped in the deep modes
         sys_clk_en <= gear_tick & sph_r & ~((st_r == ST_HALT) &&
                       (mode_r != `HALT_PERIPH_IDLE)); // R2 R16 R18
         if (prescaler_source_select_r == `PRESC_FIXED) begin
            prescaler_base_a <= fix_tick & fph_r[0]; // R6 R8
            prescaler_base_b <= fix_tick & (fph_r == 2'h3); // R7
         end else begin
            // Reserved codes fall back to the gear path
            prescaler_base_a <= gear_tick & gph_r[0]; // R6 R8
            prescaler_base_b <= gear_tick & (gph_r == 2'h3); // R7
         end
      end
   end

   // Halt state machine
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_r         <= ST_RUN; // R26
         mode_r       <= `RST_HALT;
         ent_cnt_r    <= 3'd0;
         hold_r       <= 1'b0;
         svc_r        <= 1'b0;
         wake_service <= 1'b0;
         wake_resume  <= 1'b0;
      end else begin
         wake_service <= 1'b0;
         wake_resume  <= 1'b0;
         case (st_r)
            ST_RUN: begin
               if (halt_req) begin
                  mode_r    <= halt_kind_select_r; // R13
                  ent_cnt_r <= 3'd0;
                  // Peripheral idle has no entry window
                  st_r <= (halt_kind_select_r == `HALT_PERIPH_IDLE) ? ST_HALT : ST_ENTER;
               end
            end
            ST_ENTER: begin
               if (nmi_s | ext_s)
                  hold_r <= 1'b1; // R24
               if (gear_tick) begin
                  ent_cnt_r <= ent_cnt_r + 3'd1;
                  if (ent_cnt_r == `ENTER_TICKS - 3'd1)
                     st_r <= ST_HALT;
               end
            end
            ST_HALT: begin
               if (wake) begin
                  hold_r <= 1'b0;
                  if (mode_r == `HALT_STOP) begin
                     svc_r <= svc;
                     st_r  <= ST_WARM; // R23
                  end else begin
                     wake_service <= svc; // R20
                     wake_resume  <= ~svc; // R21
                     st_r         <= ST_RUN; // R25
                  end
               end
            end
            ST_WARM: begin
               if (wu_done) begin
                  wake_service <= svc_r; // R18 R23
                  wake_resume  <= ~svc_r;
                  st_r         <= ST_RUN;
               end
            end
            default: st_r <= ST_RUN;
         endcase
      end
   end

   // Halt side effects on oscillator, pins and peripherals
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         osc_run         <= 1'b1;
         cpu_halted      <= 1'b0;
         pin_hold        <= 1'b0;
         timer_pair0_run <= 1'b1;
         timer16_run     <= 1'b1;
         serial_run      <= 1'b1;
         converter_run   <= 1'b1;
         watchdog_run    <= 1'b1;
      end else begin
         // Oscillator off only while fully stopped
         osc_run    <= ~((st_r == ST_HALT) && (mode_r == `HALT_STOP)) | wake; // R16 R17
         cpu_halted <= (st_r != ST_RUN);
         pin_hold   <= (st_r == ST_HALT) && (mode_r != `HALT_STOP); // R15
         if (st_r != ST_HALT && st_r != ST_WARM) begin
            {watchdog_run, converter_run, serial_run, timer16_run, timer_pair0_run} <= 5'h1F;
         end else if (mode_r == `HALT_PERIPH_IDLE) begin
            {watchdog_run, converter_run, serial_run, timer16_run, timer_pair0_run} <= idle_run_r; // R14
         end else begin
            {watchdog_run, converter_run, serial_run, timer16_run, timer_pair0_run} <= 5'h00; // R16 R17
         end
      end
   end

endmodule // clock_gear_standby_controller

/* verification/clock_gear_checker.sv */
`timescale 1ns/1ps
module clock_gear_checker (
   // Clock and reset
   input wire        pclk,
   input wire        presetn,
   // Register writes
   input wire        psel,
   input wire        penable,
   input wire        pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   // Halt and wake
   input wire        nmi_pin,
   input wire [4:0]  external_wake_interrupts,
   input wire        wake_service,
   input wire        wake_resume,
   input wire        cpu_halted,
   input wire        sys_clk_en,
   input wire        osc_run,
   input wire        pin_hold
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   reg  [1:0] kind_r;
   reg  [9:0] halt_r;
   reg  [9:0] pin_r;
   reg        pin_q_r;
   wire       wake    = wake_service | wake_resume;
   wire       pin_any = nmi_pin | (|external_wake_interrupts);
   // Halt kind shadow; only valid while writes go in unprotected
   always @(posedge pclk or negedge presetn)
      if (!presetn) begin
         kind_r <= 2'h3;
         halt_r <= 10'h000;
         pin_r  <= 10'h000;
         pin_q_r <= 1'b0;
      end else begin
         pin_q_r <= pin_any;
         if (psel && penable && pwrite && paddr == 12'h388)
            kind_r <= pwdata[3:2];
         halt_r <= cpu_halted ? halt_r + {9'h000, halt_r != 10'h3FF} : 10'h000;
         pin_r  <= (pin_any & ~pin_q_r) ? 10'h000 : pin_r + {9'h000, pin_r != 10'h3FF};
      end
   wake_single_a: assert property (!(wake_service && wake_resume))
      else $error("service and resume together");
   wake_release_a: assert property (wake |=> !cpu_halted)
      else $error("halt kept after wake");
   hold_halted_a: assert property (pin_hold |-> cpu_halted)
      else $error("pins held while running");
   osc_stop_a: assert property (!osc_run |-> cpu_halted && kind_r == 2'h1 && !sys_clk_en)
      else $error("oscillator off outside stop");
   oscillator_only_idle_mode_clock_a: assert property (halt_r > 10'd100 && cpu_halted && kind_r == 2'h2 && !wake |-> !sys_clk_en)
      else $error("system clock in oscillator idle");
   quiet_wake_a: assert property ((cpu_halted && kind_r != 2'h3 && !nmi_pin && external_wake_interrupts == 5'h00)[*6]
      |-> !wake)
      else $error("deep halt left without pin");
   pin_wake_a: assert property (halt_r > 10'd100 && kind_r != 2'h1 && $rose(|external_wake_interrupts)
      |-> ##[1:6] wake)
      else $error("idle not left after pin");
   stop_warm_a: assert property (wake && kind_r == 2'h1 |-> pin_r >= 10'd256)
      else $error("stop left before warm-up");
   cover property (wake_service);
   cover property (wake_resume);
   cover property (!osc_run);
endmodule // clock_gear_checker

/* verification/cpu_osc_partner.sv */
`timescale 1ns/1ps
module cpu_osc_partner (
   // Clock
   input  wire       pclk,
   // Wake answer
   input  wire       wake_service,
   input  wire       wake_resume,
   // Halt and levels
   output reg        halt_req,
   output reg  [2:0] interrupt_mask_level,
   output reg        periph_irq,
   output reg  [2:0] periph_irq_level,
   output reg  [2:0] ext_irq_level,
   // Wake pins
   output reg        nmi_pin,
   output reg  [4:0] external_wake_interrupts
);
   initial begin
      halt_req = 1'b0;
      interrupt_mask_level = 3'h7;
      periph_irq = 1'b0;
      periph_irq_level = 3'h0;
      ext_irq_level = 3'h0;
      nmi_pin = 1'b0;
      external_wake_interrupts = 5'h00;
   end
   // Level request kept until the core answers
   always @(posedge pclk)
      if (wake_service || wake_resume) begin
         nmi_pin <= 1'b0;
         external_wake_interrupts <= 5'h00;
      end
   task halt;
      @(posedge pclk);
      halt_req <= 1'b1;
      @(posedge pclk);
      halt_req <= 1'b0;
   endtask
   task irq(input [2:0] m, input r, input [2:0] pl, input [2:0] el);
      @(posedge pclk);
      interrupt_mask_level <= m;
      periph_irq <= r;
      periph_irq_level <= pl;
      ext_irq_level <= el;
   endtask
   task pins(input [4:0] x, input n);
      @(posedge pclk);
      external_wake_interrupts <= x;
      nmi_pin <= n;
   endtask
endmodule // cpu_osc_partner

/* verification/tb_clock_gear_standby_controller.sv */
`timescale 1ns/1ps
module tb_clock_gear_standby_controller;
   reg         pclk;
   reg         presetn;
   reg         psel;
   reg         penable;
   reg         pwrite;
   reg  [11:0] paddr;
   reg  [31:0] pwdata;
   wire [31:0] prdata;
   wire [2:0]  interrupt_mask_level, periph_irq_level, ext_irq_level;
   wire [4:0]  external_wake_interrupts;
   wire        pready, pslverr, halt_req, periph_irq, nmi_pin, wake_service, wake_resume, cpu_halted;
   wire        gear_clock, sys_clk_en, prescaler_base_a, prescaler_base_b, osc_run, pin_hold;
   wire        external_clock_single_drive, stop_pin_drive_enable;
   wire        timer_pair0_run, timer16_run, serial_run, converter_run, watchdog_run;
   wire [3:0]  ticks = {prescaler_base_b, prescaler_base_a, sys_clk_en, gear_clock};
   int         mismatches;
   int         checks_done;

   clock_gear_standby_controller #(.WARM_MID_CYC(300), .WARM_LONG_CYC(600)) i_clock_gear_standby_controller (
      .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr,
      .halt_req, .interrupt_mask_level, .periph_irq, .periph_irq_level, .ext_irq_level,
      .wake_service, .wake_resume, .cpu_halted, .nmi_pin, .external_wake_interrupts,
      .gear_clock, .sys_clk_en, .prescaler_base_a, .prescaler_base_b, .osc_run,
      .external_clock_single_drive, .pin_hold, .stop_pin_drive_enable,
      .timer_pair0_run, .timer16_run, .serial_run, .converter_run, .watchdog_run);
   cpu_osc_partner i_cpu_osc_partner (.pclk, .wake_service, .wake_resume, .halt_req, .interrupt_mask_level,
      .periph_irq, .periph_irq_level, .ext_irq_level, .nmi_pin, .external_wake_interrupts);

   task check(input [31:0] seen, input [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         mismatches++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task final_report;
      if (mismatches == 0 && checks_done > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   task stall;
      mismatches++;
      final_report;
   endtask
   task apb(input w, input [11:0] a, input [7:0] d);
      int k;
      k = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h000000, d};
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         k++;
      end while (pready !== 1'b1 && k < 50);
      if (k >= 50)
         stall;
      check({pslverr, w || a > 12'h394 ? 8'h00 : prdata[7:0]}, {a > 12'h394, w ? 8'h00 : d});
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task gap(input [1:0] s, input int x);
      int k;
      k = 0;
      do begin
         @(posedge pclk);
         k++;
      end while (ticks[s] !== 1'b1 && k < 200);
      k = 0;
      do begin
         @(posedge pclk);
         k++;
      end while (ticks[s] !== 1'b1 && k < 200);
      if (k >= 200)
         stall;
      check(k, x);
   endtask
   task await_wake(input [1:0] x, input int lo);
      int k;
      k = 0;
      do begin
         @(posedge pclk);
         k++;
      end while (!(wake_service || wake_resume) && k < 600);
      if (k >= 600)
         stall;
      check({wake_service, wake_resume}, x);
      check(k >= lo, 1);
   endtask
   task t_regs;
      apb(0, 12'h380, 8'hA0);
      apb(0, 12'h384, 8'h04);
      apb(0, 12'h388, 8'h2C);
      apb(0, 12'h38C, 8'h23);
      apb(0, 12'h398, 8'h00);
      apb(1, 12'h390, 8'h00);
      apb(0, 12'h38C, 8'hA3);
      apb(1, 12'h384, 8'h00);
      apb(0, 12'h384, 8'h04);
      apb(1, 12'h390, 8'h1F);
      apb(0, 12'h38C, 8'h23);
      apb(1, 12'h38C, 8'h27);
      @(posedge pclk);
      check(external_clock_single_drive, 1'b1);
      apb(1, 12'h38C, 8'h23);
   endtask
   task t_gear;
      apb(1, 12'h388, 8'h1C);
      apb(1, 12'h384, 8'h00);
      apb(1, 12'h394, 8'h13);
      apb(0, 12'h380, 8'hA4);
      gap(0, 16);
      repeat (300) @(posedge pclk);
      gap(0, 1);
      gap(1, 2);
      apb(1, 12'h384, 8'h01);
      repeat (300) @(posedge pclk);
      gap(1, 4);
      gap(2, 4);
      gap(3, 8);
      apb(1, 12'h380, 8'h02);
      repeat (70) @(posedge pclk);
      gap(2, 32);
      gap(3, 64);
      apb(1, 12'h380, 8'h03);
      repeat (70) @(posedge pclk);
      gap(2, 4);
   endtask
   task t_peripheral_idle_mode;
      i_cpu_osc_partner.irq(3'h2, 1'b1, 3'h1, 3'h1);
      i_cpu_osc_partner.halt;
      repeat (120) @(posedge pclk);
      check({cpu_halted, pin_hold}, 2'h3);
      check({timer_pair0_run, timer16_run, serial_run, converter_run, watchdog_run}, 5'h19);
      i_cpu_osc_partner.irq(3'h2, 1'b1, 3'h3, 3'h1);
      await_wake(2'h2, 1);
      i_cpu_osc_partner.irq(3'h2, 1'b0, 3'h0, 3'h1);
      i_cpu_osc_partner.halt;
      repeat (120) @(posedge pclk);
      i_cpu_osc_partner.pins(5'h01, 1'b0);
      await_wake(2'h1, 1);
   endtask
   task t_oscillator_only_idle_mode;
      apb(1, 12'h388, 8'h18);
      i_cpu_osc_partner.irq(3'h2, 1'b1, 3'h5, 3'h1);
      i_cpu_osc_partner.halt;
      // Pulse inside the entry window must be held, not wake
      i_cpu_osc_partner.pins(5'h00, 1'b1);
      repeat (3) @(posedge pclk);
      i_cpu_osc_partner.pins(5'h00, 1'b0);
      repeat (120) @(posedge pclk);
      check({cpu_halted, sys_clk_en}, 2'h2);
      check({timer_pair0_run, timer16_run, serial_run, converter_run, watchdog_run}, 5'h00);
      i_cpu_osc_partner.pins(5'h02, 1'b0);
      await_wake(2'h2, 1);
   endtask
   task t_stop;
      apb(1, 12'h388, 8'h15);
      i_cpu_osc_partner.irq(3'h2, 1'b0, 3'h0, 3'h0);
      i_cpu_osc_partner.halt;
      repeat (120) @(posedge pclk);
      check({osc_run, stop_pin_drive_enable}, 2'h1);
      i_cpu_osc_partner.pins(5'h00, 1'b1);
      await_wake(2'h2, 256);
      i_cpu_osc_partner.halt;
      repeat (120) @(posedge pclk);
      // Ideal bench clock: no settling time to allow for after this reset
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      check({cpu_halted, osc_run}, 2'h1);
      apb(0, 12'h384, 8'h04);
   endtask

   initial begin
      pclk = 1'b0;
      forever #2.5 pclk = ~pclk;
   end
   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h00000000;
      mismatches = 0;
      checks_done = 0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      t_regs;
      t_gear;
      t_peripheral_idle_mode;
      t_oscillator_only_idle_mode;
      t_stop;
      final_report;
   end
endmodule // tb_clock_gear_standby_controller

bind clock_gear_standby_controller clock_gear_checker i_clock_gear_checker (.pclk, .presetn, .psel, .penable,
   .pwrite, .paddr, .pwdata, .nmi_pin, .external_wake_interrupts, .wake_service, .wake_resume, .cpu_halted,
   .sys_clk_en, .osc_run, .pin_hold);
